// ---- hdl/tsr_pkg.sv ----
// Package for the two-wire slave register access front end
// Functional notes
// R1: Answer address 0110100 with strap low, 0110101 with strap high; last bit is R/W.
// R2: Write with sub address top bit 0 keeps pointer fixed for every data byte.
// R3: Write with sub address top bit 1 advances pointer after each data byte.
// R4: Read without sub address returns register set by the latest write.
// R5: Read after sub address with top bit 0 repeats that register until stop.
// R6: Read after sub address with top bit 1 returns consecutive registers until stop.
// R7: Link runs at standard 100 kbps and fast 400 kbps; high speed unsupported.
// R8: Slave only; never makes start, stop or drives the serial clock.
// R9: Low seven sub address bits form the pointer; top bit selects auto increment.
package tsr_pkg;

   // ==========================================================
   // Addressing
   localparam logic [5:0] SLAVE_ADDR_HI   = 6'h1A;   // Upper six bits 011010
   localparam int         PTR_W           = 7;
   localparam logic [6:0] PTR_RESET       = 7'h00;
   localparam logic [7:0] BYTE_RESET      = 8'h00;
   localparam logic [3:0] BIT_CNT_RESET   = 4'h0;
   localparam logic [3:0] BIT_CNT_LAST    = 4'h8;
   localparam logic [3:0] BIT_CNT_ACK     = 4'h9;   // Acknowledge slot after eight bits

   // ==========================================================
   // Link rate figures
   localparam int CLK_MHZ        = 125;
   localparam int FAST_RATE_KBPS = 400;
   localparam int STD_RATE_KBPS  = 100;
   // Clock cycles per fast-mode bit, for information of users
   localparam int FAST_BIT_CYCLES = (CLK_MHZ * 1000) / FAST_RATE_KBPS;

   // ==========================================================
   // Protocol states
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_ADDR = 6'b000010,
      ST_SUB  = 6'b000100,
      ST_WDAT = 6'b001000,
      ST_RDAT = 6'b010000,
      ST_ACK  = 6'b100000
   } tsr_state_t;

   // Register side write request
   typedef struct packed {
      logic       en;
      logic [6:0] addr;
      logic [7:0] data;
   } tsr_wr_t;

endpackage : tsr_pkg

// ---- hdl/tsr_sync.sv ----
// Two flip-flop synchroniser with edge detection of the settled level
`timescale 1ns/10ps
`default_nettype none
module tsr_sync (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   input  wire logic d_i,
   output logic      q_o,
   output logic      rise_o,
   output logic      fall_o
);
   logic s1_reg, s2_reg, s3_reg;
   logic s1_next, s2_next, s3_next;

   // Next values: hold while the clock enable is low
   always_comb begin
      s1_next = ce_i ? d_i : s1_reg;
      s2_next = ce_i ? s1_reg : s2_reg;
      s3_next = ce_i ? s2_reg : s3_reg;
   end

   // Registers, idle bus level is high
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         s3_reg <= s3_next;
      end
   end

   assign q_o    = s2_reg;
   assign rise_o = s2_reg & ~s3_reg;
   assign fall_o = ~s2_reg & s3_reg;
endmodule : tsr_sync
`default_nettype wire

// ---- hdl/tsr_slave.sv ----
// Two-wire serial slave that reads and writes an internal register space
`timescale 1ns/10ps
`default_nettype none
module tsr_slave (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   input  wire logic             scl_i,
   input  wire logic             sda_i,
   output logic                  sda_oe_n_o,
   input  wire logic             address_select_strap_i,
   output tsr_pkg::tsr_wr_t      wr_o,
   output logic [6:0]            rd_addr_o,
   input  wire logic [7:0]       rd_data_i,
   output logic                  busy_o
);
   // ==========================================================
   // Input synchronisers
   logic scl_s, scl_rise, scl_fall, sda_s, sda_rise, sda_fall;

   tsr_sync u_scl (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .d_i    (scl_i),
      .q_o    (scl_s),
      .rise_o (scl_rise),
      .fall_o (scl_fall)
   );

   tsr_sync u_sda (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .d_i    (sda_i),
      .q_o    (sda_s),
      .rise_o (sda_rise),
      .fall_o (sda_fall)
   );

   // ==========================================================
   // Strap pin synchroniser; a static level, but still a pin from outside
   logic strap_s;

   tsr_sync u_strap (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .d_i    (address_select_strap_i),
      .q_o    (strap_s),
      .rise_o (),
      .fall_o ()
   );

   // ==========================================================
   // State
   tsr_pkg::tsr_state_t state_reg, state_next, after_ack_reg, after_ack_next;
   logic [3:0] bit_cnt_reg, bit_cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [6:0] ptr_reg, ptr_next;
   logic       inc_reg, inc_next;
   logic       oe_n_reg, oe_n_next;
   logic       drive_reg, drive_next;
   logic       nack_reg, nack_next;
   tsr_pkg::tsr_wr_t wr_reg, wr_next;
   logic       busy_reg, busy_next;

   logic start_cond, stop_cond;
   logic addr_match;

   // Start and stop seen while the clock line is high
   assign start_cond = sda_fall & scl_s;
   assign stop_cond  = sda_rise & scl_s;

   // Slave address compare with strap as bit one
   assign addr_match = (shift_reg[7:2] == tsr_pkg::SLAVE_ADDR_HI) &&
                       (shift_reg[1] == strap_s);   // see R1

   // Next state and data path; only SDA is ever driven, never SCL   see R8
   always_comb begin
      state_next     = state_reg;
      after_ack_next = after_ack_reg;
      bit_cnt_next   = bit_cnt_reg;
      shift_next     = shift_reg;
      ptr_next       = ptr_reg;
      inc_next       = inc_reg;
      drive_next     = drive_reg;
      nack_next      = nack_reg;
      wr_next        = wr_reg;
      wr_next.en     = 1'b0;
      busy_next      = busy_reg;
      if (ce_i) begin
         if (stop_cond) begin
            // Stop ends any transfer; pointer and mode are kept
            state_next = tsr_pkg::ST_IDLE;
            drive_next = 1'b0;
            busy_next  = 1'b0;
         end else if (start_cond) begin
            state_next   = tsr_pkg::ST_ADDR;
            bit_cnt_next = tsr_pkg::BIT_CNT_RESET;
            drive_next   = 1'b0;
            busy_next    = 1'b1;
         end else begin
            unique case (state_reg)
               tsr_pkg::ST_IDLE: begin
                  drive_next = 1'b0;
               end
               tsr_pkg::ST_ADDR, tsr_pkg::ST_SUB, tsr_pkg::ST_WDAT: begin
                  // Sample on rising clock, MSB first
                  if (scl_rise) begin
                     shift_next   = {shift_reg[6:0], sda_s};
                     bit_cnt_next = bit_cnt_reg + 4'h1;
                  end
                  if (scl_fall && bit_cnt_reg == tsr_pkg::BIT_CNT_LAST) begin
                     bit_cnt_next = tsr_pkg::BIT_CNT_RESET;
                     state_next   = tsr_pkg::ST_ACK;
                     drive_next   = 1'b1;
                     if (state_reg == tsr_pkg::ST_ADDR) begin
                        if (!addr_match) begin
                           state_next = tsr_pkg::ST_IDLE;
                           drive_next = 1'b0;
                        end else begin
                           // Read with no sub address reuses pointer   see R4
                           after_ack_next = shift_reg[0] ? tsr_pkg::ST_RDAT
                                                         : tsr_pkg::ST_SUB;
                        end
                     end else if (state_reg == tsr_pkg::ST_SUB) begin
                        ptr_next       = shift_reg[6:0];              // see R9
                        inc_next       = shift_reg[7];                // see R9
                        after_ack_next = tsr_pkg::ST_WDAT;
                     end else begin
                        wr_next.en     = 1'b1;
                        wr_next.addr   = ptr_reg;
                        wr_next.data   = shift_reg;
                        // Fixed or advancing pointer on write   see R2 see R3
                        ptr_next       = inc_reg ? ptr_reg + 7'h01 : ptr_reg;
                        after_ack_next = tsr_pkg::ST_WDAT;
                     end
                  end
               end
               tsr_pkg::ST_ACK: begin
                  // Release after the acknowledge clock falls, or for a read drive bit 7 of the first byte
                  if (scl_fall) begin
                     state_next = after_ack_reg;
                     if (after_ack_reg == tsr_pkg::ST_RDAT) begin
                        shift_next = rd_data_i;
                        drive_next = ~rd_data_i[7];
                        bit_cnt_next = 4'h1;
                     end else begin
                        drive_next = 1'b0;
                     end
                  end
               end
               tsr_pkg::ST_RDAT: begin
                  if (scl_fall) begin
                     if (bit_cnt_reg == tsr_pkg::BIT_CNT_LAST) begin
                        // Last data bit is over: release and enter the acknowledge slot
                        drive_next   = 1'b0;
                        bit_cnt_next = tsr_pkg::BIT_CNT_ACK;
                     end else if (bit_cnt_reg == tsr_pkg::BIT_CNT_ACK) begin
                        // Master ack ended; a nack means no more bytes
                        if (nack_reg) begin
                           state_next = tsr_pkg::ST_IDLE;
                           drive_next = 1'b0;
                        end else begin
                           shift_next   = rd_data_i;
                           drive_next   = ~rd_data_i[7];
                           bit_cnt_next = 4'h1;
                        end
                     end else begin
                        shift_next   = {shift_reg[6:0], 1'b0};
                        drive_next   = ~shift_reg[6];
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                     end
                  end
                  // Master acknowledge is sampled in the ninth bit, never in the
                  // eighth, so the last data bit is not taken for it
                  if (scl_rise && bit_cnt_reg == tsr_pkg::BIT_CNT_ACK) begin
                     nack_next    = sda_s;
                     // Repeat or advance after each byte read   see R5 see R6
                     ptr_next     = inc_reg ? ptr_reg + 7'h01 : ptr_reg;
                  end
               end
               default: begin
                  state_next = tsr_pkg::ST_IDLE;
                  drive_next = 1'b0;
               end
            endcase
         end
      end
      // Pin enable kept in its own flop so the output needs no gate
      oe_n_next = ~drive_next;
   end

   // Registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg     <= tsr_pkg::ST_IDLE;
         after_ack_reg <= tsr_pkg::ST_IDLE;
         bit_cnt_reg   <= tsr_pkg::BIT_CNT_RESET;
         shift_reg     <= tsr_pkg::BYTE_RESET;
         ptr_reg       <= tsr_pkg::PTR_RESET;
         inc_reg       <= 1'b0;
         oe_n_reg      <= 1'b1;
         drive_reg     <= 1'b0;
         nack_reg      <= 1'b0;
         wr_reg        <= '0;
         busy_reg      <= 1'b0;
      end else begin
         state_reg     <= state_next;
         after_ack_reg <= after_ack_next;
         bit_cnt_reg   <= bit_cnt_next;
         shift_reg     <= shift_next;
         ptr_reg       <= ptr_next;
         inc_reg       <= inc_next;
         oe_n_reg      <= oe_n_next;
         drive_reg     <= drive_next;
         nack_reg      <= nack_next;
         wr_reg        <= wr_next;
         busy_reg      <= busy_next;
      end
   end

   // Outputs from flip-flops; enable is low while pulling SDA low   see R7
   assign sda_oe_n_o = oe_n_reg;
   assign wr_o       = wr_reg;
   assign rd_addr_o  = ptr_reg;
   assign busy_o     = busy_reg;
endmodule : tsr_slave
`default_nettype wire

// ---- verif/tsr_slave_chk.sv ----
// Port checker for the two-wire slave
`timescale 1ns/10ps
`default_nettype none
module tsr_slave_chk (
   input wire logic             clk_i,
   input wire logic             rst_i,
   input wire logic             scl_i,
   input wire logic             sda_i,
   input wire logic             sda_oe_n_o,
   input wire tsr_pkg::tsr_wr_t wr_o,
   input wire logic [6:0]       rd_addr_o,
   input wire logic             busy_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========================================
   // Properties
   property p_idle_rel; !busy_o |-> sda_oe_n_o; endproperty
   property p_busy_start; $rose(busy_o) |-> scl_i; endproperty
   property p_busy_stop; $fell(busy_o) |-> scl_i && sda_i; endproperty
   property p_oe_scl; $changed(sda_oe_n_o) |-> !scl_i; endproperty
   property p_wr_busy; wr_o.en |-> busy_o; endproperty
   property p_wr_pulse; wr_o.en |=> !wr_o.en; endproperty
   property p_wr_addr; wr_o.en |-> wr_o.addr == $past(rd_addr_o); endproperty
   property p_wr_hold; !wr_o.en |-> $stable(wr_o.data) && $stable(wr_o.addr); endproperty
   property p_ptr_hold; !busy_o |=> $stable(rd_addr_o); endproperty
   a_idle_rel: assert property (p_idle_rel)
      else $error("data line driven outside a frame");
   a_busy_start: assert property (p_busy_start)
      else $error("frame began with clock low");
   a_busy_stop: assert property (p_busy_stop)
      else $error("frame ended without stop");
   a_oe_scl: assert property (p_oe_scl)
      else $error("data drive changed while clock high");
   a_wr_busy: assert property (p_wr_busy)
      else $error("write strobe outside a frame");
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("write strobe longer than one cycle");
   a_wr_addr: assert property (p_wr_addr)
      else $error("write address differs from pointer");
   a_wr_hold: assert property (p_wr_hold)
      else $error("write fields moved without strobe");
   a_ptr_hold: assert property (p_ptr_hold)
      else $error("pointer moved between frames");
   c_write: cover property (wr_o.en);
   c_drive: cover property (!sda_oe_n_o ##1 sda_oe_n_o);
   c_end: cover property ($fell(busy_o));
endmodule : tsr_slave_chk
`default_nettype wire

// ---- verif/tsr_master_bfm.sv ----
// Two-wire bus master model
`timescale 1ns/10ps
`default_nettype none
module tsr_master_bfm (
   input  wire logic clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   logic scl_reg = 1'b1;
   logic sda_reg = 1'b1;
   assign scl_o = scl_reg;
   assign sda_o = sda_reg;
   task automatic hold(input int n);
      repeat (n) @(posedge clk_i);
   endtask : hold
   // One bit of 80 ns: data mid low phase, sampled late in high phase
   task automatic bit_x(input logic b, output logic s);
      hold(1);
      scl_reg <= 1'b0;
      hold(2);
      sda_reg <= b;
      hold(3);
      scl_reg <= 1'b1;
      hold(4);
      s = sda_i;
   endtask : bit_x
   // Start (1,0) or stop (0,1); clock stands still from idle
   task automatic cond(input logic d0, input logic d1);
      if (!(sda_i && d0)) begin
         hold(1);
         scl_reg <= 1'b0;
         hold(2);
         sda_reg <= d0;
         hold(6);
         scl_reg <= 1'b1;
      end
      hold(5);
      sda_reg <= d1;
      hold(5);
   endtask : cond
   task automatic wbyte(input logic [7:0] d, output logic nack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(d[i], s);
      bit_x(1'b1, nack);
   endtask : wbyte
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
      bit_x(last, s);
   endtask : rbyte
endmodule : tsr_master_bfm
`default_nettype wire

// ---- verif/test_i2c_slave_register_access.sv ----
// Bench for the two-wire slave register access block
`timescale 1ns/10ps
`default_nettype none
module test_i2c_slave_register_access;
   logic             clk_i = 1'b0;
   logic             rst_i = 1'b1;
   logic             strap = 1'b0;
   logic             ce    = 1'b1;
   logic             busy;
   logic             scl;
   logic             m_sda;
   logic             sda;
   logic             sda_oe_n;
   tsr_pkg::tsr_wr_t wr;
   logic [6:0]       rd_addr;
   logic [7:0]       mem [128];
   int               n_fail = 0;
   int               checks_done = 0;
   // Clock, pulled-up data wire, register space
   always #4 clk_i = ~clk_i;
   assign sda = m_sda & sda_oe_n;
   always @(posedge clk_i) if (wr.en) mem[wr.addr] <= wr.data;
   tsr_slave i_tsr_slave (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .scl_i(scl), .sda_i(sda),
      .sda_oe_n_o(sda_oe_n), .address_select_strap_i(strap), .wr_o(wr), .rd_addr_o(rd_addr),
      .rd_data_i(mem[rd_addr]), .busy_o(busy));
   tsr_master_bfm i_tsr_master_bfm (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test
   // Write frame: address, sub address, n data bytes, no stop
   task automatic frame(input logic [7:0] sub, input int n, input logic [7:0] d0);
      logic a;
      i_tsr_master_bfm.cond(1'b1, 1'b0);
      i_tsr_master_bfm.wbyte(8'h68, a);
      cmp("addr_ack", 8'h00, {7'h00, a});
      cmp("busy_on", 8'h01, {7'h00, busy});
      i_tsr_master_bfm.wbyte(sub, a);
      cmp("sub_ack", 8'h00, {7'h00, a});
      for (int i = 0; i < n; i++) begin
         i_tsr_master_bfm.wbyte(d0 + 8'(i), a);
         cmp("data_ack", 8'h00, {7'h00, a});
      end
   endtask : frame
   task automatic stop;
      i_tsr_master_bfm.cond(1'b0, 1'b1);
      cmp("busy_off", 8'h00, {7'h00, busy});
   endtask : stop
   // Read frame of three bytes, last one refused
   task automatic reads(input logic [23:0] exp);
      logic [7:0] d;
      logic       a;
      i_tsr_master_bfm.cond(1'b1, 1'b0);
      i_tsr_master_bfm.wbyte(8'h69, a);
      cmp("raddr_ack", 8'h00, {7'h00, a});
      for (int i = 0; i < 3; i++) begin
         i_tsr_master_bfm.rbyte(i == 2, d);
         cmp("rdata", exp[23 - 8 * i -: 8], d);
      end
      stop();
   endtask : reads
   task automatic t_addr;
      logic a;
      for (int s = 0; s < 2; s++) for (int k = 0; k < 2; k++) begin
         @(posedge clk_i) strap <= s[0];
         i_tsr_master_bfm.cond(1'b1, 1'b0);
         i_tsr_master_bfm.wbyte({6'h1A, k[0], 1'b0}, a);
         stop();
         cmp("addr_nack", {7'h00, k != s}, {7'h00, a});
      end
      @(posedge clk_i) strap <= 1'b0;
      $display("t_addr done");
   endtask : t_addr
   // Clock enable low: a matching address must go unanswered
   task automatic t_ce;
      logic a;
      @(posedge clk_i) ce <= 1'b0;
      i_tsr_master_bfm.cond(1'b1, 1'b0);
      i_tsr_master_bfm.wbyte(8'h68, a);
      stop();
      cmp("frozen_ack", 8'h01, {7'h00, a});
      cmp("frozen_ptr", 8'h00, {1'b0, rd_addr});
      @(posedge clk_i) ce <= 1'b1;
      $display("t_ce done");
   endtask : t_ce
   task automatic t_wr;
      frame(8'h05, 3, 8'h30);
      stop();
      cmp("fixed_reg", 8'h32, mem[5]);
      cmp("fixed_next", 8'h86, mem[6]);
      reads(24'h323232);
      frame(8'h90, 3, 8'h40);
      stop();
      cmp("inc_reg", 8'h40, mem[16]);
      cmp("inc_last", 8'h42, mem[18]);
      cmp("inc_past", 8'h93, mem[19]);
      $display("t_wr done");
   endtask : t_wr
   task automatic t_rd;
      frame(8'h10, 0, 8'h00);
      reads(24'h404040);
      frame(8'h91, 0, 8'h00);
      reads(24'h414293);
      $display("t_rd done");
   endtask : t_rd
   initial begin
      for (int i = 0; i < 128; i++) mem[i] = {1'b1, 7'(i)};
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      cmp("reset_oe", 8'h01, {7'h00, sda_oe_n});
      t_addr();
      t_ce();
      t_wr();
      t_rd();
      end_of_test();
   end
   initial begin
      repeat (100000) @(posedge clk_i);
      n_fail++;
      end_of_test();
   end
endmodule : test_i2c_slave_register_access
bind tsr_slave tsr_slave_chk i_tsr_slave_chk (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i),
   .sda_i(sda_i), .sda_oe_n_o(sda_oe_n_o), .wr_o(wr_o), .rd_addr_o(rd_addr_o), .busy_o(busy_o));
`default_nettype wire
